// ---- verilog/t16w_timer.sv ----
// 16-bit timer/counter with compare outputs and five waveform families.
// Assumes a register master that never issues read and write together and
// port logic outside that gates the compare levels with the pin direction.
`timescale 1ns/1ps

// Behaviour
// - A new compare action acts at the next match; force applies it at once in non-PWM.
// - Mode select fixes counting; compare action only picks the pin action.
// - Mode zero counts up always and wraps from 0xFFFF to 0x0000.
// - Normal mode sets the overflow flag as the count becomes zero.
// - Software may write the counter at any time.
// - Modes 4 and 12 clear the counter at compare A or capture value.
// - Buffered modes load compare values from their buffer at top, except modes 8 and 9, which load at bottom.
// - Fast PWM action two is non-inverted, three is inverted.
// - Fast PWM changes output at compare match and at the top-to-bottom wrap.
// - Fast PWM compare zero gives a spike; compare at top gives a steady level.
// - Mode 15 with action one toggles output A at each match.
// - The tick divides the system clock by 1, 8, 64, 256 or 1024.
// - Phase correct modes count bottom to top and back down, repeatedly.
// - Dual-slope non-inverted clears on up match and sets on down match.
// - Phase correct top is fixed 8, 9, 10 bit or a register, at least 2-bit.
// - Dual-slope compare at bottom holds low, at top holds high, non-inverted.
// - Mode 9 with action one toggles output A at each match.
// - All logic runs on the system clock with the tick as an enable.
module t16w_timer import t16w_pkg::*; (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [REG_ADDR_W-1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Compare outputs
  output logic cmp_out_pin_a,
  output logic cmp_out_pin_b,
  output logic cmp_out_drive_a,
  output logic cmp_out_drive_b,
  // Status
  output logic overflow_flag
);

  logic [3:0] wave_mode_sel;
  logic [1:0][1:0] cmp_out_action;
  logic [2:0] clk_sel;
  logic [15:0] count_value;
  logic [1:0][15:0] cmp_reg_chan;
  logic [1:0][15:0] cmp_buf;
  logic [15:0] capture_reg;
  t16w_dir_t dir;
  logic [1:0] cmp_flag;
  logic [1:0] pin;
  logic [1:0] drive;
  logic timer_tick_enable;

  t16w_class_t cls;
  logic [15:0] raw_top;
  logic [15:0] top;
  logic at_top;
  logic at_bottom;
  logic cur_up;
  logic nonpwm;
  logic buffered;
  logic load_active;
  logic ovf_set;
  logic toggle_a;
  logic [15:0] next_count;
  t16w_dir_t next_dir;
  logic wr_ctrl;
  logic wr_force;
  logic wr_count;
  logic wr_flags;
  logic [1:0] wr_cmp;

  t16w_prescale u_prescale (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .clk_sel(clk_sel),
    .timer_tick_enable(timer_tick_enable)
  );

  // Write decode
  assign wr_ctrl = reg_wr && (reg_addr == OFS_CTRL);
  assign wr_force = reg_wr && (reg_addr == OFS_FORCE);
  assign wr_count = reg_wr && (reg_addr == OFS_COUNT);
  assign wr_flags = reg_wr && (reg_addr == OFS_FLAGS);
  assign wr_cmp[0] = reg_wr && (reg_addr == OFS_CMP_A);
  assign wr_cmp[1] = reg_wr && (reg_addr == OFS_CMP_B);

  // Mode decode: only wave_mode_sel shapes counting
  assign cls = t16w_mode_class(wave_mode_sel);
  assign raw_top = t16w_top(wave_mode_sel, cmp_reg_chan[0], capture_reg);
  assign nonpwm = (cls == CL_NORMAL) || (cls == CL_CTC);
  assign buffered = !nonpwm;

  // Dual-slope tops below 2-bit resolution would stall the direction logic
  always_comb begin
    top = raw_top;
    if (((cls == CL_PC) || (cls == CL_PFC)) && (raw_top < TOP_MIN_DUAL)) begin
      top = TOP_MIN_DUAL;
    end
  end

  assign at_top = (count_value == top);
  assign at_bottom = (count_value == CNT_BOTTOM);
  // Direction that applies to a match at the current count
  assign cur_up = at_bottom || (!at_top && (dir == DIR_UP));

  // Counting sequence
  always_comb begin
    next_count = count_value;
    next_dir = dir;
    case (cls)
      CL_NORMAL: begin
        next_count = count_value + 16'h0001;
        next_dir = DIR_UP;
      end
      CL_CTC, CL_FAST: begin
        next_count = at_top ? CNT_BOTTOM : count_value + 16'h0001;
        next_dir = DIR_UP;
      end
      CL_PC, CL_PFC: begin
        if (cur_up && !at_top) begin
          next_count = count_value + 16'h0001;
          next_dir = DIR_UP;
        end else begin
          next_count = count_value - 16'h0001;
          next_dir = DIR_DOWN;
        end
      end
      default: begin
        next_count = count_value + 16'h0001;
        next_dir = DIR_UP;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_value <= RST_WORD;
      dir <= DIR_UP;
    end else if (wr_count) begin
      count_value <= reg_wdata;
    end else if (timer_tick_enable) begin
      count_value <= next_count;
      dir <= next_dir;
    end
  end

  // Control register
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wave_mode_sel <= RST_MODE;
      cmp_out_action <= '0;
      clk_sel <= RST_CLK_SEL;
    end else if (wr_ctrl) begin
      wave_mode_sel <= reg_wdata[CTRL_MODE_LSB +: 4];
      cmp_out_action[0] <= reg_wdata[CTRL_ACT_A_LSB +: 2];
      cmp_out_action[1] <= reg_wdata[CTRL_ACT_B_LSB +: 2];
      clk_sel <= reg_wdata[CTRL_CLK_LSB +: 3];
    end
  end

  // Capture register acts here only as a top value
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      capture_reg <= RST_WORD;
    end else if (reg_wr && (reg_addr == OFS_CAPTURE)) begin
      capture_reg <= reg_wdata;
    end
  end

  // Buffer load point: top for fast and phase correct, bottom for the other
  assign load_active = timer_tick_enable && ((cls == CL_PFC) ? at_bottom : at_top);

  // Overflow point per family
  always_comb begin
    case (cls)
      CL_NORMAL, CL_CTC: ovf_set = timer_tick_enable && (count_value == CNT_MAX);
      CL_FAST: ovf_set = timer_tick_enable && at_top;
      default: ovf_set = timer_tick_enable && at_bottom;
    endcase
  end

  // Toggle on channel A in PWM modes is only offered where compare A is the top
  assign toggle_a = (wave_mode_sel == 4'hF) || (wave_mode_sel == 4'h9) ||
                    (wave_mode_sel == 4'hB);

  // Flag register: hardware set wins over a write-one clear
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      overflow_flag <= 1'b0;
    end else if (ovf_set) begin
      overflow_flag <= 1'b1;
    end else if (wr_flags && reg_wdata[FLG_OVF]) begin
      overflow_flag <= 1'b0;
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_chan
      logic match;
      logic [1:0] act;
      logic tog;

      assign match = (count_value == cmp_reg_chan[ch]);
      assign act = cmp_out_action[ch];
      assign tog = (ch == 0) && toggle_a && (act == 2'h1);

      // Compare register and its buffer
      always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
          cmp_buf[ch] <= RST_WORD;
          cmp_reg_chan[ch] <= RST_WORD;
        end else begin
          if (wr_cmp[ch]) begin
            cmp_buf[ch] <= reg_wdata;
          end
          if (wr_cmp[ch] && !buffered) begin
            cmp_reg_chan[ch] <= reg_wdata;
          end else if (buffered && load_active) begin
            cmp_reg_chan[ch] <= cmp_buf[ch];
          end
        end
      end

      always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
          cmp_flag[ch] <= 1'b0;
        end else if (timer_tick_enable && match) begin
          cmp_flag[ch] <= 1'b1;
        end else if (wr_flags && reg_wdata[FLG_CMP_A + ch]) begin
          cmp_flag[ch] <= 1'b0;
        end
      end

      // Output level: actions are sampled at the event, so a new action waits for it
      always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
          pin[ch] <= 1'b0;
        end else if (wr_force && reg_wdata[ch] && nonpwm) begin
          pin[ch] <= t16w_apply(act, pin[ch]);
        end else if (timer_tick_enable) begin
          case (cls)
            CL_NORMAL, CL_CTC: begin
              if (match) begin
                pin[ch] <= t16w_apply(act, pin[ch]);
              end
            end
            CL_FAST: begin
              if (tog) begin
                if (match) begin
                  pin[ch] <= ~pin[ch];
                end
              end else if (act[1]) begin
                if (at_top) begin
                  pin[ch] <= ~act[0];
                end else if (match) begin
                  pin[ch] <= act[0];
                end
              end
            end
            CL_PC, CL_PFC: begin
              if (tog) begin
                if (match) begin
                  pin[ch] <= ~pin[ch];
                end
              end else if (act[1] && match) begin
                pin[ch] <= cur_up ? act[0] : ~act[0];
              end
            end
            default: pin[ch] <= pin[ch];
          endcase
        end
      end

      // The waveform owns the pin only where the action selects an output
      assign drive[ch] = (act != 2'h0) && (nonpwm || act[1] || tog);
    end
  endgenerate

  assign cmp_out_pin_a = pin[0];
  assign cmp_out_pin_b = pin[1];
  assign cmp_out_drive_a = drive[0];
  assign cmp_out_drive_b = drive[1];

  // Read port: data stand only in the cycle after the strobe
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= RST_WORD;
    end else if (reg_rd) begin
      case (reg_addr)
        OFS_CTRL: reg_rdata <= {5'h00, clk_sel, cmp_out_action[1], cmp_out_action[0],
                                wave_mode_sel};
        OFS_COUNT: reg_rdata <= count_value;
        OFS_CMP_A: reg_rdata <= cmp_buf[0];
        OFS_CMP_B: reg_rdata <= cmp_buf[1];
        OFS_CAPTURE: reg_rdata <= capture_reg;
        OFS_FLAGS: reg_rdata <= {13'h0000, cmp_flag, overflow_flag};
        OFS_STATUS: reg_rdata <= {13'h0000, (dir == DIR_DOWN), pin};
        default: reg_rdata <= RST_WORD;
      endcase
    end else begin
      reg_rdata <= RST_WORD;
    end
  end

endmodule

// ---- verilog/t16w_pkg.sv ----
// Constants, types and decode helpers of the 16-bit waveform timer.
// Assumes one 100 MHz system clock; the timer tick is a clock enable.
package t16w_pkg;

  // Register port
  localparam int REG_ADDR_W = 3;
  localparam logic [2:0] OFS_CTRL = 3'h0;
  localparam logic [2:0] OFS_FORCE = 3'h1;
  localparam logic [2:0] OFS_COUNT = 3'h2;
  localparam logic [2:0] OFS_CMP_A = 3'h3;
  localparam logic [2:0] OFS_CMP_B = 3'h4;
  localparam logic [2:0] OFS_CAPTURE = 3'h5;
  localparam logic [2:0] OFS_FLAGS = 3'h6;
  localparam logic [2:0] OFS_STATUS = 3'h7;

  // Control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_ACT_A_LSB = 4;
  localparam int CTRL_ACT_B_LSB = 6;
  localparam int CTRL_CLK_LSB = 8;

  // Flag register fields
  localparam int FLG_OVF = 0;
  localparam int FLG_CMP_A = 1;
  localparam int FLG_CMP_B = 2;

  // Reset values
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [3:0] RST_MODE = 4'h0;
  localparam logic [2:0] RST_CLK_SEL = 3'h0;

  // Counter limits
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] CNT_BOTTOM = 16'h0000;
  localparam logic [15:0] TOP_8BIT = 16'h00FF;
  localparam logic [15:0] TOP_9BIT = 16'h01FF;
  localparam logic [15:0] TOP_10BIT = 16'h03FF;
  localparam logic [15:0] TOP_MIN_DUAL = 16'h0003;

  // Prescaler: a tick whenever the free counter's masked bits are all ones
  localparam logic [9:0] PRE_MASK_1 = 10'h000;
  localparam logic [9:0] PRE_MASK_8 = 10'h007;
  localparam logic [9:0] PRE_MASK_64 = 10'h03F;
  localparam logic [9:0] PRE_MASK_256 = 10'h0FF;
  localparam logic [9:0] PRE_MASK_1024 = 10'h3FF;

  typedef enum logic [2:0] {
    CL_NORMAL = 3'b000,
    CL_CTC = 3'b001,
    CL_FAST = 3'b010,
    CL_PC = 3'b011,
    CL_PFC = 3'b100
  } t16w_class_t;

  typedef enum logic {
    DIR_UP = 1'b0,
    DIR_DOWN = 1'b1
  } t16w_dir_t;

  function automatic t16w_class_t t16w_mode_class(input logic [3:0] mode);
    case (mode)
      4'h1, 4'h2, 4'h3, 4'hA, 4'hB: t16w_mode_class = CL_PC;
      4'h4, 4'hC: t16w_mode_class = CL_CTC;
      4'h5, 4'h6, 4'h7, 4'hE, 4'hF: t16w_mode_class = CL_FAST;
      4'h8, 4'h9: t16w_mode_class = CL_PFC;
      default: t16w_mode_class = CL_NORMAL;
    endcase
  endfunction

  function automatic logic [15:0] t16w_top(input logic [3:0] mode, input logic [15:0] cmp_a,
                                           input logic [15:0] cap);
    case (mode)
      4'h1, 4'h5: t16w_top = TOP_8BIT;
      4'h2, 4'h6: t16w_top = TOP_9BIT;
      4'h3, 4'h7: t16w_top = TOP_10BIT;
      4'h4, 4'h9, 4'hB, 4'hF: t16w_top = cmp_a;
      4'h8, 4'hA, 4'hC, 4'hE: t16w_top = cap;
      default: t16w_top = CNT_MAX;
    endcase
  endfunction

  // Pin action of a non-PWM compare match or force
  function automatic logic t16w_apply(input logic [1:0] act, input logic pin);
    case (act)
      2'h1: t16w_apply = ~pin;
      2'h2: t16w_apply = 1'b0;
      2'h3: t16w_apply = 1'b1;
      default: t16w_apply = pin;
    endcase
  endfunction

endpackage

// ---- verilog/t16w_prescale.sv ----
// Prescaler giving the timer tick enable from the system clock.
// Assumes clk_sel is stable software state; selections 0, 6 and 7 stop the timer.
`timescale 1ns/1ps
module t16w_prescale import t16w_pkg::*; (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Divider selection and tick
  input wire logic [2:0] clk_sel,
  output logic timer_tick_enable
);

  logic [9:0] div_count;
  logic [9:0] mask;
  logic run;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_count <= 10'h000;
    end else begin
      div_count <= div_count + 10'h001;
    end
  end

  always_comb begin
    run = 1'b1;
    case (clk_sel)
      3'h1: mask = PRE_MASK_1;
      3'h2: mask = PRE_MASK_8;
      3'h3: mask = PRE_MASK_64;
      3'h4: mask = PRE_MASK_256;
      3'h5: mask = PRE_MASK_1024;
      default: begin
        mask = PRE_MASK_1;
        run = 1'b0;
      end
    endcase
  end

  // Shared free counter keeps the divider phase across selection changes
  assign timer_tick_enable = run && ((div_count & mask) == mask);

endmodule

// ---- verification/t16w_timer_properties.sv ----
// Checker for the waveform timer, bound to its top module.
// Assumes one strobe at a time and read data in the cycle after a read.
`timescale 1ns/1ps
module t16w_timer_chk import t16w_pkg::*; (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [REG_ADDR_W-1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // Compare outputs and status
  input wire logic cmp_out_pin_a,
  input wire logic cmp_out_pin_b,
  input wire logic cmp_out_drive_a,
  input wire logic cmp_out_drive_b,
  input wire logic overflow_flag
);
  // Control register rebuilt from bus writes
  logic [15:0] ctrl;
  logic [3:0] mode;
  logic [1:0] act_a;
  logic non_pwm;
  logic fast;
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl <= 16'h0000;
    end else if (reg_wr && reg_addr == OFS_CTRL) begin
      ctrl <= reg_wdata;
    end
  end
  assign mode = ctrl[3:0];
  assign act_a = ctrl[5:4];
  assign non_pwm = mode inside {4'h0, 4'h4, 4'hC, 4'hD};
  assign fast = mode inside {4'h5, 4'h6, 4'h7, 4'hE, 4'hF};
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  property p_rdata_idle;
    !reg_rd |=> reg_rdata == 16'h0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside a read");
  property p_ctrl_read;
    reg_rd && reg_addr == OFS_CTRL |=> reg_rdata[10:0] == ctrl[10:0];
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("control read back wrong");
  property p_status_read;
    reg_rd && reg_addr == OFS_STATUS |=> reg_rdata[1:0] == $past({cmp_out_pin_b, cmp_out_pin_a});
  endproperty
  a_status_read: assert property (p_status_read) else $error("status pins wrong");
  property p_stopped;
    ctrl[10:8] == 3'h0 && !reg_wr |=> $stable({cmp_out_pin_a, cmp_out_pin_b, overflow_flag});
  endproperty
  a_stopped: assert property (p_stopped) else $error("outputs moved while stopped");
  property p_force;
    non_pwm && act_a[1] && reg_wr && reg_addr == OFS_FORCE && reg_wdata[0]
      |=> cmp_out_pin_a == act_a[0];
  endproperty
  a_force: assert property (p_force) else $error("force did not apply action");
  property p_flag_clear;
    ctrl[10:8] == 3'h0 && reg_wr && reg_addr == OFS_FLAGS && reg_wdata[0] |=> !overflow_flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("overflow not cleared");
  property p_ovf_wrap;
    (mode == 4'h0 && ctrl[10:8] == 3'h1 && reg_wr && reg_addr == OFS_COUNT
      && reg_wdata == CNT_MAX) ##1 !reg_wr |=> overflow_flag;
  endproperty
  a_ovf_wrap: assert property (p_ovf_wrap) else $error("no overflow at wrap");
  property p_no_drive;
    act_a == 2'h0 |-> !cmp_out_drive_a;
  endproperty
  a_no_drive: assert property (p_no_drive) else $error("pin driven without action");
  property p_drive_pwm;
    fast && act_a[1] |-> cmp_out_drive_a;
  endproperty
  a_drive_pwm: assert property (p_drive_pwm) else $error("pwm pin not driven");
  c_force: cover property (reg_wr && reg_addr == OFS_FORCE);
  c_ovf: cover property ($rose(overflow_flag));
  c_fast: cover property (fast && $rose(cmp_out_pin_a));
endmodule

bind t16w_timer t16w_timer_chk i_chk (.sys_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .cmp_out_pin_a, .cmp_out_pin_b, .cmp_out_drive_a, .cmp_out_drive_b,
  .overflow_flag);

// ---- verification/t16w_pin_port.sv ----
// Pad model: shows a compare level only while the pin is an output.
// Assumes level and drive come from the timer, dir from the pin direction.
`timescale 1ns/1ps
module t16w_pin_port (
  // Clock
  input wire logic sys_clk,
  // Timer side and direction
  input wire logic level,
  input wire logic drive,
  input wire logic dir,
  // Pad
  output logic pad
);
  logic last = 1'b0;
  // A released pad flips each cycle so a stale level never passes for a drive
  always @(posedge sys_clk) begin
    if (dir && drive) begin
      last <= level;
    end else begin
      last <= ~last;
    end
  end
  assign pad = (dir && drive) ? level : last;
endmodule

// ---- verification/test_t16w_timer.sv ----
// Self-checking bench of the waveform timer with a pad model on output A.
// Assumes a 100 MHz clock and the register map of the package.
`timescale 1ns/1ps
module test_t16w_timer import t16w_pkg::*; ;
  typedef struct {logic [15:0] c; logic [15:0] a; logic [15:0] cap; logic [15:0] cnt;
    int n; logic [15:0] exp; logic ovf;} t16w_row_t;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [2:0] reg_addr = 3'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic pin_a, pin_b, drv_a, drv_b, ovf, pad_a;
  logic [15:0] rv;
  int num_errors = 0;
  int n_compared = 0;
  int ha, hb, ca;
  t16w_row_t rows[19] = '{
    '{16'h0100, 16'h0000, 16'h0000, 16'hFFFE, 2, 16'h0000, 1'b1},
    '{16'h0130, 16'hFFF1, 16'h0000, 16'hFFF0, 3, 16'hFFF3, 1'b0},
    '{16'h0104, 16'h0005, 16'h0000, 16'h0000, 7, 16'h0001, 1'b0},
    '{16'h010C, 16'h0000, 16'h0003, 16'h0000, 4, 16'h0000, 1'b0},
    '{16'h010A, 16'h0000, 16'h0003, 16'h0000, 5, 16'h0001, 1'b1},
    '{16'h010B, 16'h0004, 16'h0000, 16'h0000, 6, 16'h0002, 1'b1},
    '{16'h0105, 16'h0000, 16'h0000, 16'h00FE, 3, 16'h0001, 1'b1},
    '{16'h0108, 16'h0000, 16'h0004, 16'h0000, 6, 16'h0002, 1'b1},
    '{16'h010D, 16'h0000, 16'h0000, 16'hFFFF, 2, 16'h0001, 1'b1},
    '{16'h0200, 16'h0000, 16'h0000, 16'h0000, 64, 16'h0008, 1'b0},
    '{16'h0300, 16'h0000, 16'h0000, 16'h0000, 128, 16'h0002, 1'b0},
    '{16'h0400, 16'h0000, 16'h0000, 16'h0000, 512, 16'h0002, 1'b0},
    '{16'h0500, 16'h0000, 16'h0000, 16'h0000, 2048, 16'h0002, 1'b0},
    '{16'h0600, 16'h0000, 16'h0000, 16'h0000, 8, 16'h0000, 1'b0},
    '{16'h0103, 16'h0000, 16'h0000, 16'h03FE, 3, 16'h03FD, 1'b0},
    '{16'h0107, 16'h0000, 16'h0000, 16'h03FE, 3, 16'h0001, 1'b1},
    '{16'h0102, 16'h0000, 16'h0000, 16'h01FE, 3, 16'h01FD, 1'b0},
    '{16'h0106, 16'h0000, 16'h0000, 16'h01FE, 3, 16'h0001, 1'b1},
    '{16'h0101, 16'h0000, 16'h0000, 16'h00FE, 3, 16'h00FD, 1'b0}};
  always #5 sys_clk = ~sys_clk;
  t16w_timer i_t16w_timer (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cmp_out_pin_a(pin_a), .cmp_out_pin_b(pin_b), .cmp_out_drive_a(drv_a),
    .cmp_out_drive_b(drv_b), .overflow_flag(ovf));
  t16w_pin_port i_pad_a (.sys_clk(sys_clk), .level(pin_a), .drive(drv_a), .dir(1'b1),
    .pad(pad_a));
  task automatic results();
    if (num_errors == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Strobe stays up so back-to-back writes need no second assignment
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_rd <= 1'b0;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
  endtask
  task automatic idle(input int n);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    reg_addr <= a;
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge sys_clk);
  endtask
  // Compare and top values go in while in mode zero, where writes are direct
  task automatic prep(input logic [15:0] c, a, b, cap, cnt);
    wr(OFS_CTRL, 16'h0000);
    wr(OFS_CMP_A, a);
    wr(OFS_CMP_B, b);
    wr(OFS_CAPTURE, cap);
    wr(OFS_COUNT, cnt);
    wr(OFS_FLAGS, 16'h0007);
    wr(OFS_CTRL, c & 16'hF8FF);
  endtask
  // Exactly n timer ticks when the divider is one, n cycles otherwise
  task automatic run(input logic [15:0] c, input int n);
    wr(OFS_CTRL, c);
    idle(n - 1);
    wr(OFS_CTRL, c & 16'hF8FF);
  endtask
  task automatic go(input logic [15:0] c, a, b, cap);
    prep(c, a, b, cap, 16'h0000);
    wr(OFS_CTRL, c);
    idle(16);
  endtask
  task automatic meas(input int n);
    logic la;
    ha = 0;
    hb = 0;
    ca = 0;
    @(negedge sys_clk);
    la = pin_a;
    repeat (n) begin
      @(negedge sys_clk);
      ha += pin_a;
      hb += pin_b;
      ca += (pin_a != la);
      la = pin_a;
    end
    @(posedge sys_clk);
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    results();
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd(OFS_CTRL, rv);
    chk("ctrl reset", 16'h0000, rv);
    rd(OFS_COUNT, rv);
    chk("count reset", 16'h0000, rv);
    chk("outputs reset", 16'h0000, {11'h000, pin_a, pin_b, drv_a, drv_b, ovf});
    prep(16'h0130, 16'h0005, 16'h0000, 16'h0000, 16'h0000);
    run(16'h0130, 3);
    rd(OFS_STATUS, rv);
    chk("pin a before match", 16'h0000, {15'h0000, rv[0]});
    run(16'h0130, 3);
    wr(OFS_CTRL, 16'h0020);
    rd(OFS_STATUS, rv);
    chk("pin a at match", 16'h0001, {15'h0000, rv[0]});
    wr(OFS_FORCE, 16'h0001);
    rd(OFS_STATUS, rv);
    chk("pin a forced", 16'h0000, {15'h0000, rv[0]});
    rd(OFS_FLAGS, rv);
    chk("match flags", 16'h0006, rv);
    foreach (rows[i]) begin
      prep(rows[i].c, rows[i].a, 16'h0000, rows[i].cap, rows[i].cnt);
      run(rows[i].c, rows[i].n);
      rd(OFS_COUNT, rv);
      chk("count", rows[i].exp, rv);
      chk("overflow", {15'h0000, rows[i].ovf}, {15'h0000, ovf});
    end
    // Counter written while running: the write beats that tick, then it wraps
    wr(OFS_CTRL, 16'h0100);
    wr(OFS_FLAGS, 16'h0007);
    wr(OFS_COUNT, 16'hFFFF);
    idle(2);
    wr(OFS_CTRL, 16'h0000);
    rd(OFS_COUNT, rv);
    chk("count written while running", 16'h0002, rv);
    chk("overflow at wrap", 16'h0001, {15'h0000, ovf});
    go(16'h01EE, 16'h0003, 16'h0001, 16'h0007);
    meas(16);
    chk("fast a high", 16'h0008, ha[15:0]);
    chk("fast b high", 16'h000C, hb[15:0]);
    @(negedge sys_clk);
    chk("pad a", {15'h0000, pin_a}, {15'h0000, pad_a});
    @(posedge sys_clk);
    wr(OFS_CMP_A, 16'h0007);
    wr(OFS_CMP_B, 16'h0000);
    wr(OFS_CTRL, 16'h01AE);
    idle(24);
    meas(16);
    chk("top level", 16'h0010, ha[15:0]);
    chk("spike", 16'h0002, hb[15:0]);
    go(16'h011F, 16'h0001, 16'h0000, 16'h0000);
    meas(16);
    chk("mode 15 toggles", 16'h0008, ca[15:0]);
    go(16'h0119, 16'h0004, 16'h0000, 16'h0000);
    meas(32);
    chk("mode 9 toggles", 16'h0004, ca[15:0]);
    chk("mode 9 duty", 16'h0010, ha[15:0]);
    go(16'h01EA, 16'h0002, 16'h0000, 16'h0007);
    meas(28);
    chk("dual a high", 16'h0008, ha[15:0]);
    chk("dual b bottom", 16'h001C, hb[15:0]);
    chk("drive b", 16'h0001, {15'h0000, drv_b});
    // Reset in mid-run must drop every output and the control state
    sys_rst <= 1'b1;
    idle(2);
    chk("mid-run reset", 16'h0000, {11'h000, pin_a, pin_b, drv_a, drv_b, ovf});
    sys_rst <= 1'b0;
    rd(OFS_CTRL, rv);
    chk("ctrl after mid-run reset", 16'h0000, rv);
    results();
  end
endmodule
